// ===== srw_params.svh
// constants for the sleep, reset and watchdog control block
`ifndef SRW_PARAMS_SVH
`define SRW_PARAMS_SVH

// ----------------------------------------------------------------
// register indices (byte address = index * 4)
// ----------------------------------------------------------------
`define SRW_IDX_WDC      6'h21
`define SRW_IDX_CAUSE    6'h34
`define SRW_IDX_PMC      6'h35
`define SRW_IDX_GATE     6'h36

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define SRW_PMC_ARM      5
`define SRW_PMC_SEL_HI   4
`define SRW_PMC_SEL_LO   3
`define SRW_PMC_WMASK    8'h7B
`define SRW_PMC_RST      8'h00
`define SRW_WDC_IF       7
`define SRW_WDC_IE       6
`define SRW_WDC_P3       5
`define SRW_WDC_UNL      4
`define SRW_WDC_EN       3
`define SRW_CAUSE_POR    0
`define SRW_CAUSE_EXT    1
`define SRW_CAUSE_BOD    2
`define SRW_CAUSE_WD     3
`define SRW_BOD_OFF      3'h7

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SRW_CLK_HZ       40000000
`define SRW_CLK_MHZ      40
`define SRW_WDT_OSC_HZ   128000
`define SRW_WDT_DIV      (`SRW_CLK_HZ / `SRW_WDT_OSC_HZ)
`define SRW_WDT_BASE_CYC 2048
`define SRW_WDT_MAX_SEL  9
`define SRW_UNLOCK_CYC   4
`define SRW_EXT_MIN_NS   2500
`define SRW_EXT_MIN_CYC  ((`SRW_EXT_MIN_NS * `SRW_CLK_MHZ + 999) / 1000)
`define SRW_BOD_MIN_NS   2000
`define SRW_BOD_MIN_CYC  ((`SRW_BOD_MIN_NS * `SRW_CLK_MHZ + 999) / 1000)
`define SRW_DLY_UNIT_CYC 4096

`endif

// ===== srw_pkg.sv
// types for the sleep, reset and watchdog control block
`default_nettype none

package srw_pkg;

    // reset sequencer states, gray along hold-stretch-run
    typedef enum logic [1:0] {
        SRW_HOLD    = 2'b00,
        SRW_STRETCH = 2'b01,
        SRW_RUN     = 2'b11
    } srw_rst_state_t;

    // sleep modes
    typedef enum logic [1:0] {
        SRW_IDLE  = 2'b00,
        SRW_NOISE = 2'b01,
        SRW_PDOWN = 2'b10,
        SRW_STBY  = 2'b11
    } srw_sleep_mode_t;

endpackage : srw_pkg

`default_nettype wire

// ===== srw_tick_div.sv
// divider making the watchdog oscillator enable pulse
`timescale 1ns/1ps
`default_nettype none

module srw_tick_div #(
    parameter int DIV = 312
) (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // enable pulse
    output logic      tick_o
);
    import srw_pkg::*;

    typedef struct packed {
        logic [15:0] cnt;
        logic        tick;
    } srw_div_t;

    srw_div_t q, d;

    always_comb begin
        d = q;
        d.tick = 1'b0;
        if (q.cnt == 16'(DIV - 1)) begin
            d.cnt = 16'h0000;
            d.tick = 1'b1;
        end else begin
            d.cnt = q.cnt + 16'h0001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign tick_o = q.tick;

endmodule : srw_tick_div

`default_nettype wire

// ===== srw_top.sv
// sleep control, clock gating, reset merging and watchdog
//
// Register access over Wishbone was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "srw_params.svh"

// Functional notes
// - sleep instruction sleeps only while the sleep-arm bit is one
// - sleep-select field picks idle, noise reduction, power-down, standby
// - upper four gating bits read as zero
// - gating bit 3 freezes timer one, clearing resumes it
// - gating bit 2 freezes timer zero, clearing resumes it
// - gating bit 1 stops serial unit clock; software reinitialises it
// - gating bit 0 shuts converter; comparator loses converter mux
// - any reset returns control registers to initial values
// - port pins reset at once when power-on, pin or enabled brown-out asserts, clockless
// - delay counter stretches internal reset by fuse-chosen time
// - internal reset merges power-on, pin, watchdog, brown-out sources
// - long low pin pulse resets; release starts delay counter
// - power-on reset reasserts at once; release through delay counter
// - lasting brown-out asserts reset; release after delay counter
// - watchdog reset is a one-cycle pulse; delay starts at its end
// - bandgap on for brown-out fuse, comparator select or converter
// - watchdog counts its own 128 kHz oscillator ticks
// - kick, disable and chip reset clear the watchdog counter
// - expiry resets the device or raises an interrupt
// - ten selectable watchdog periods
// - lock fuse sets safety level one or two
// - unlock with enable starts a four-cycle change window
// - with reset enable set, expiry clears the interrupt enable
// - at level one the watchdog cause flag forces reset enable
// - time-out flag clears on vector taken or write of one
module srw_top #(
    parameter int DLY_UNIT = `SRW_DLY_UNIT_CYC,
    parameter int WDT_DIV  = `SRW_WDT_DIV
) (
    // clock and reset
    input  wire logic                    clk_i,
    input  wire logic                    rst_i,
    // wishbone slave
    input  wire logic                    wb_cyc_i,
    input  wire logic                    wb_stb_i,
    input  wire logic                    wb_we_i,
    input  wire logic [7:0]              wb_adr_i,
    input  wire logic [3:0]              wb_sel_i,
    input  wire logic [31:0]             wb_dat_i,
    output logic      [31:0]             wb_dat_o,
    output logic                         wb_ack_o,
    // reset source pins
    input  wire logic                    por_i,
    input  wire logic                    ext_rst_n_i,
    input  wire logic                    bod_low_i,
    // fuses
    input  wire logic                    watchdog_lock_fuse_i,
    input  wire logic [2:0]              brownout_level_fuse_i,
    input  wire logic [1:0]              startup_time_fuse_i,
    input  wire logic [3:0]              clock_select_fuse_i,
    // core events and levels
    input  wire logic                    sleep_instr_i,
    input  wire logic                    wake_i,
    input  wire logic                    watchdog_kick_instr_i,
    input  wire logic                    wd_vector_taken_i,
    input  wire logic                    comparator_bandgap_select_i,
    input  wire logic                    converter_en_i,
    // reset outputs
    output logic                         sys_rst_o,
    output logic                         port_rst_o,
    // sleep and clock gating
    output logic                         sleep_o,
    output srw_pkg::srw_sleep_mode_t     sleep_select_o,
    output logic                         gate_timer_one_o,
    output logic                         gate_timer_zero_o,
    output logic                         gate_serial_unit_o,
    output logic                         gate_converter_o,
    output logic                         cmp_mux_ok_o,
    // reference and watchdog
    output logic                         bandgap_en_o,
    output logic                         wd_irq_o
);
    import srw_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic            ack;
        logic [7:0]      rdat;
        logic            ext_m;
        logic            ext_s;
        logic            por_m;
        logic            por_s;
        logic            bod_m;
        logic            bod_s;
        logic [9:0]      fuse_m;
        logic [9:0]      fuse_s;
        logic [7:0]      ext_cnt;
        logic [7:0]      bod_cnt;
        srw_rst_state_t  rst_st;
        logic [23:0]     dly_cnt;
        logic            sys_rst;
        logic [7:0]      pmc;
        logic [3:0]      gate;
        logic            wd_timeout_flag;
        logic            wd_irq_enable;
        logic            wd_reset_enable;
        logic [3:0]      wdp;
        logic            unlock;
        logic [2:0]      unl_cnt;
        logic [19:0]     wd_cnt;
        logic            wd_pulse;
        logic [3:0]      cause;
        logic            sleeping;
        srw_sleep_mode_t smode;
        logic            irq;
        logic            bg_en;
        logic            cmp_ok;
    } srw_state_t;

    srw_state_t q, d;

    logic        tick;
    logic        port_rst_q;
    logic        port_rst_src;

    // ----------------------------------------------------------------
    // watchdog oscillator enable
    // ----------------------------------------------------------------
    srw_tick_div #(
        .DIV    (WDT_DIV)
    ) u_wdt_div (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .tick_o (tick)
    );

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        logic        lock;
        logic        bod_en;
        logic        ext_hit;
        logic        bod_hit;
        logic        src;
        logic [2:0]  shift;
        logic [23:0] dly_len;
        logic        acc;
        logic        wr;
        logic [5:0]  idx;
        logic [7:0]  w;
        logic        wde_eff;
        logic        run;
        logic [3:0]  pc;
        logic [19:0] lim;

        d = q;

        // pin synchronisers
        d.ext_m  = ext_rst_n_i;
        d.ext_s  = q.ext_m;
        d.por_m  = por_i;
        d.por_s  = q.por_m;
        d.bod_m  = bod_low_i;
        d.bod_s  = q.bod_m;
        d.fuse_m = {watchdog_lock_fuse_i, brownout_level_fuse_i,
                    startup_time_fuse_i, clock_select_fuse_i};
        d.fuse_s = q.fuse_m;

        lock   = q.fuse_s[9];
        bod_en = (q.fuse_s[8:6] != `SRW_BOD_OFF);

        // pin and brown-out minimum duration filters
        ext_hit = (q.ext_cnt == 8'(`SRW_EXT_MIN_CYC));
        bod_hit = (q.bod_cnt == 8'(`SRW_BOD_MIN_CYC));
        if (!q.ext_s) begin
            if (!ext_hit) begin
                d.ext_cnt = q.ext_cnt + 8'h01;
            end
        end else begin
            d.ext_cnt = 8'h00;
        end
        if (bod_en && q.bod_s) begin
            if (!bod_hit) begin
                d.bod_cnt = q.bod_cnt + 8'h01;
            end
        end else begin
            d.bod_cnt = 8'h00;
        end

        // reset sequencer
        src     = q.por_s | ext_hit | bod_hit | q.wd_pulse;
        shift   = {1'b0, q.fuse_s[5:4]} + {2'b00, q.fuse_s[0]};
        dly_len = 24'(DLY_UNIT) << shift;
        case (q.rst_st)
            SRW_HOLD: begin
                if (!src) begin
                    d.rst_st  = SRW_STRETCH;
                    d.dly_cnt = 24'h000000;
                end
            end
            SRW_STRETCH: begin
                if (src) begin
                    d.rst_st = SRW_HOLD;
                end else if (q.dly_cnt == dly_len - 24'h000001) begin
                    d.rst_st = SRW_RUN;
                end else begin
                    d.dly_cnt = q.dly_cnt + 24'h000001;
                end
            end
            SRW_RUN: begin
                if (src) begin
                    d.rst_st = SRW_HOLD;
                end
            end
            default: begin
                d.rst_st = SRW_HOLD;
            end
        endcase
        d.sys_rst = (d.rst_st != SRW_RUN);

        // wishbone access
        acc   = wb_cyc_i & wb_stb_i & ~q.ack;
        d.ack = acc;
        wr    = acc & wb_we_i & wb_sel_i[0];
        idx   = wb_adr_i[7:2];
        w     = wb_dat_i[7:0];

        // power control and clock gating
        if (wr && idx == `SRW_IDX_PMC) begin
            d.pmc = w & `SRW_PMC_WMASK;
        end
        if (wr && idx == `SRW_IDX_GATE) begin
            d.gate = w[3:0];
        end

        // sleep entry and wake
        if (sleep_instr_i && q.pmc[`SRW_PMC_ARM]) begin
            d.sleeping = 1'b1;
            d.smode = srw_sleep_mode_t'(q.pmc[`SRW_PMC_SEL_HI:`SRW_PMC_SEL_LO]);
        end
        if (wake_i) begin
            d.sleeping = 1'b0;
        end

        // watchdog control
        wde_eff = q.wd_reset_enable | lock | q.cause[`SRW_CAUSE_WD];
        if (q.unlock) begin
            if (q.unl_cnt == 3'(`SRW_UNLOCK_CYC - 1)) begin
                d.unlock = 1'b0;
            end else begin
                d.unl_cnt = q.unl_cnt + 3'h1;
            end
        end
        if (wd_vector_taken_i) begin
            d.wd_timeout_flag = 1'b0;
        end
        if (wr && idx == `SRW_IDX_WDC) begin
            d.wd_irq_enable = w[`SRW_WDC_IE];
            d.irq  = 1'b0;
            if (w[`SRW_WDC_IF]) begin
                d.wd_timeout_flag = 1'b0;
            end
            if (!lock) begin
                if (w[`SRW_WDC_EN]) begin
                    d.wd_reset_enable = 1'b1;
                end else if (q.unlock) begin
                    d.wd_reset_enable = 1'b0;
                end
                d.wdp = {w[`SRW_WDC_P3], w[2:0]};
            end else if (q.unlock) begin
                d.wdp = {w[`SRW_WDC_P3], w[2:0]};
            end
            if (w[`SRW_WDC_UNL] && w[`SRW_WDC_EN]) begin
                d.unlock  = 1'b1;
                d.unl_cnt = 3'h0;
            end else begin
                d.unlock = 1'b0;
            end
        end

        // watchdog counter
        pc = (q.wdp > 4'(`SRW_WDT_MAX_SEL)) ? 4'(`SRW_WDT_MAX_SEL) : q.wdp;
        lim = (20'(`SRW_WDT_BASE_CYC) << pc) - 20'h00001;
        run = wde_eff | q.wd_irq_enable;
        d.wd_pulse = 1'b0;
        if (!run || watchdog_kick_instr_i) begin
            d.wd_cnt = 20'h00000;
        end else if (tick) begin
            if (q.wd_cnt == lim) begin
                d.wd_cnt = 20'h00000;
                if (q.wd_irq_enable) begin
                    d.wd_timeout_flag = 1'b1;
                    d.irq  = 1'b1;
                    if (wde_eff) begin
                        d.wd_irq_enable = 1'b0;
                    end
                end else begin
                    d.wd_pulse = 1'b1;
                end
            end else begin
                d.wd_cnt = q.wd_cnt + 20'h00001;
            end
        end

        // reset cause flags, set wins over clear
        if (wr && idx == `SRW_IDX_CAUSE) begin
            d.cause = q.cause & w[3:0];
        end
        if (ext_hit) begin
            d.cause[`SRW_CAUSE_EXT] = 1'b1;
        end
        if (bod_hit) begin
            d.cause[`SRW_CAUSE_BOD] = 1'b1;
        end
        if (q.wd_pulse) begin
            d.cause[`SRW_CAUSE_WD] = 1'b1;
        end
        if (q.por_s) begin
            d.cause = 4'h1;
        end

        // chip reset restores control state
        if (q.sys_rst) begin
            d.pmc      = `SRW_PMC_RST;
            d.gate     = 4'h0;
            d.wd_timeout_flag     = 1'b0;
            d.wd_irq_enable     = 1'b0;
            d.wd_reset_enable      = 1'b0;
            d.wdp      = 4'h0;
            d.unlock   = 1'b0;
            d.unl_cnt  = 3'h0;
            d.wd_cnt   = 20'h00000;
            d.sleeping = 1'b0;
        end

        // read data
        case (idx)
            `SRW_IDX_PMC:   d.rdat = q.pmc;
            `SRW_IDX_GATE:  d.rdat = {4'h0, q.gate};
            `SRW_IDX_WDC:   d.rdat = {q.wd_timeout_flag, q.wd_irq_enable, q.wdp[3], q.unlock,
                                      wde_eff, q.wdp[2:0]};
            `SRW_IDX_CAUSE: d.rdat = {4'h0, q.cause};
            default:        d.rdat = 8'h00;
        endcase

        // registered outputs
        d.irq    = d.wd_timeout_flag & (d.wd_irq_enable | d.irq);
        d.bg_en  = bod_en | comparator_bandgap_select_i | converter_en_i;
        d.cmp_ok = ~d.gate[0];
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q         <= '0;
            q.ext_m   <= 1'b1;
            q.ext_s   <= 1'b1;
            q.sys_rst <= 1'b1;
            q.cmp_ok  <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // ----------------------------------------------------------------
    // clockless port reset
    // ----------------------------------------------------------------
    assign port_rst_src = por_i | ~ext_rst_n_i
                        | (bod_low_i & (brownout_level_fuse_i != `SRW_BOD_OFF));

    always_ff @(posedge clk_i or posedge port_rst_src) begin
        if (port_rst_src) begin
            port_rst_q <= 1'b1;
        end else if (rst_i) begin
            port_rst_q <= 1'b1;
        end else begin
            port_rst_q <= q.sys_rst;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign wb_dat_o           = {24'h000000, q.rdat};
    assign wb_ack_o           = q.ack;
    assign sys_rst_o          = q.sys_rst;
    assign port_rst_o         = port_rst_q;
    assign sleep_o            = q.sleeping;
    assign sleep_select_o     = q.smode;
    assign gate_timer_one_o   = q.gate[3];
    assign gate_timer_zero_o  = q.gate[2];
    assign gate_serial_unit_o = q.gate[1];
    assign gate_converter_o   = q.gate[0];
    assign cmp_mux_ok_o       = q.cmp_ok;
    assign bandgap_en_o       = q.bg_en;
    assign wd_irq_o           = q.irq;

endmodule : srw_top

`default_nettype wire

// ===== srw_top_props.sv
// concurrent checks on the ports of the sleep, reset and watchdog block
`timescale 1ns/1ps
`default_nettype none
module srw_top_props #(
    parameter int DLY_UNIT = 8,
    parameter int WDT_DIV  = 2
) (
    input wire logic                     clk_i,
    input wire logic                     rst_i,
    input wire logic                     wb_cyc_i,
    input wire logic                     wb_stb_i,
    input wire logic                     wb_we_i,
    input wire logic [7:0]               wb_adr_i,
    input wire logic [31:0]              wb_dat_o,
    input wire logic                     wb_ack_o,
    input wire logic                     por_i,
    input wire logic                     ext_rst_n_i,
    input wire logic [2:0]               brownout_level_fuse_i,
    input wire logic                     sleep_instr_i,
    input wire logic                     wake_i,
    input wire logic                     comparator_bandgap_select_i,
    input wire logic                     converter_en_i,
    input wire logic                     sys_rst_o,
    input wire logic                     port_rst_o,
    input wire logic                     sleep_o,
    input wire srw_pkg::srw_sleep_mode_t sleep_select_o,
    input wire logic                     gate_converter_o,
    input wire logic                     cmp_mux_ok_o,
    input wire logic                     bandgap_en_o
);
    import srw_pkg::*;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not acked next cycle");
    a_gate_rsvd: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'hD8 |-> wb_dat_o[31:4] == 0)
        else $error("gating reserved bits not zero");
    a_pmc_rsvd: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'hD4 |-> !wb_dat_o[7] && !wb_dat_o[2])
        else $error("power ctrl reserved bits not zero");
    a_sleep_cause: assert property ($rose(sleep_o) |-> $past(sleep_instr_i))
        else $error("sleep without instruction");
    a_sleep_wake: assert property (sleep_o && wake_i |=> !sleep_o)
        else $error("wake ignored");
    a_mode_hold: assert property (sleep_o && $past(sleep_o) |-> $stable(sleep_select_o))
        else $error("mode changed while asleep");
    a_cmp_mux: assert property (gate_converter_o |-> !cmp_mux_ok_o)
        else $error("comparator mux usable with converter off");
    a_bandgap_or: assert property (!$past(rst_i) && !$past(rst_i, 2) && !$past(rst_i, 3) |->
        bandgap_en_o == ($past(brownout_level_fuse_i, 3) != 3'h7
        || $past(comparator_bandgap_select_i) || $past(converter_en_i)))
        else $error("bandgap enable wrong");
    a_port_pin: assert property (!ext_rst_n_i || por_i |-> port_rst_o)
        else $error("port reset missing");
    a_reset_stretch: assert property ($rose(sys_rst_o) |=> sys_rst_o [*8])
        else $error("internal reset too short");
    c_sleep: cover property ($rose(sleep_o));
    c_reset: cover property ($rose(sys_rst_o));
    c_gate: cover property ($rose(gate_converter_o));
endmodule : srw_top_props
bind srw_top srw_top_props #(.DLY_UNIT(DLY_UNIT), .WDT_DIV(WDT_DIV)) u_srw_top_props (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .por_i(por_i),
    .ext_rst_n_i(ext_rst_n_i), .brownout_level_fuse_i(brownout_level_fuse_i),
    .sleep_instr_i(sleep_instr_i), .wake_i(wake_i),
    .comparator_bandgap_select_i(comparator_bandgap_select_i), .converter_en_i(converter_en_i),
    .sys_rst_o(sys_rst_o), .port_rst_o(port_rst_o), .sleep_o(sleep_o),
    .sleep_select_o(sleep_select_o), .gate_converter_o(gate_converter_o),
    .cmp_mux_ok_o(cmp_mux_ok_o), .bandgap_en_o(bandgap_en_o));
`default_nettype wire

// ===== srw_top_tb.sv
// self-checking bench for the sleep, reset and watchdog block
`timescale 1ns/1ps
`default_nettype none
`include "srw_params.svh"
module srw_top_tb;
    import srw_pkg::*;
    localparam int DLY = 8;
    localparam int WDIV = 2;
    localparam int WDP = `SRW_WDT_BASE_CYC * WDIV;
    localparam logic [7:0] WDC = {`SRW_IDX_WDC, 2'b00};
    localparam logic [7:0] CAU = {`SRW_IDX_CAUSE, 2'b00};
    localparam logic [7:0] PMC = {`SRW_IDX_PMC, 2'b00};
    localparam logic [7:0] GAT = {`SRW_IDX_GATE, 2'b00};
    logic clk_i = 0, rst_i = 1, req = 0, we = 0, lock = 0, cmp = 0, conv = 0;
    logic [7:0] adr = 0;
    logic [31:0] dat = 0, wb_dat_o;
    logic [2:0] src = 0, bfuse = 3'h7;
    logic [3:0] ev = 0;
    logic [1:0] startup_time_fuse = 0;
    logic [3:0] cks = 0;
    logic ack, sys_rst, port_rst, slp, g1, g0, gs, gc, cmp_ok, bg, irq;
    srw_sleep_mode_t mode_o;
    int error_cnt = 0, num_checks = 0, n;
    logic [31:0] q;
    srw_top #(.DLY_UNIT(DLY), .WDT_DIV(WDIV)) u_srw_top (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(ack),
        .por_i(src[2]), .ext_rst_n_i(~src[0]), .bod_low_i(src[1]),
        .watchdog_lock_fuse_i(lock), .brownout_level_fuse_i(bfuse),
        .startup_time_fuse_i(startup_time_fuse), .clock_select_fuse_i(cks),
        .sleep_instr_i(ev[0]), .wake_i(ev[1]), .watchdog_kick_instr_i(ev[2]),
        .wd_vector_taken_i(ev[3]), .comparator_bandgap_select_i(cmp), .converter_en_i(conv),
        .sys_rst_o(sys_rst), .port_rst_o(port_rst), .sleep_o(slp), .sleep_select_o(mode_o),
        .gate_timer_one_o(g1), .gate_timer_zero_o(g0), .gate_serial_unit_o(gs),
        .gate_converter_o(gc), .cmp_mux_ok_o(cmp_ok), .bandgap_en_o(bg), .wd_irq_o(irq));
    initial begin
        forever #12.5 clk_i = ~clk_i;
    end
    task automatic finish_test();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : finish_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t got %0h exp %0h", $time, got, exp);
        end
    endtask : chk
    task automatic give_up();
        error_cnt++;
        $display("BAD %0t wait timed out", $time);
        finish_test();
    endtask : give_up
    // ----------------------------------------------------------------
    // bus and event helpers
    // ----------------------------------------------------------------
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int k;
        @(posedge clk_i);
        req <= 1'b1;
        we <= w;
        adr <= a;
        dat <= {24'h0, d};
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (ack !== 1'b1 && k < 50);
        if (k >= 50) give_up();
        q = wb_dat_o;
        req <= 1'b0;
        we <= 1'b0;
    endtask : wb
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        wb(1'b1, a, d);
    endtask : wr
    task automatic rdm(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        wb(1'b0, a, 8'h00);
        chk(q & {24'h0, m}, {24'h0, e});
    endtask : rdm
    task automatic pulse(input int i);
        @(posedge clk_i);
        ev[i] <= 1'b1;
        @(posedge clk_i);
        ev <= 4'h0;
        @(negedge clk_i);
    endtask : pulse
    task automatic wait_for(input logic use_irq, input logic v, input int lim);
        n = 0;
        while ((use_irq ? irq : sys_rst) !== v) begin
            @(posedge clk_i);
            n++;
            if (n > lim) give_up();
        end
    endtask : wait_for
    task automatic do_reset();
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wait_for(1'b0, 1'b0, 400);
    endtask : do_reset
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        do_reset();
        rdm(PMC, 8'hFF, 8'h00);
        rdm(8'h10, 8'hFF, 8'h00);
        wr(PMC, 8'hFF);
        rdm(PMC, 8'hFF, 8'h7B);
        wr(GAT, 8'hFF);
        rdm(GAT, 8'hFF, 8'h0F);
        chk({g1, g0, gs, gc, cmp_ok}, 5'b11110);
        wr(GAT, 8'h00);
        rdm(GAT, 8'hFF, 8'h00);
        chk({g1, g0, gs, gc, cmp_ok}, 5'b00001);
        wr(PMC, 8'h18);
        pulse(0);
        chk(slp, 1'b0);
        for (int m = 0; m < 4; m++) begin
            wr(PMC, 8'h20 | 8'(m << 3));
            pulse(0);
            chk({slp, mode_o}, {1'b1, 2'(m)});
            pulse(1);
            chk(slp, 1'b0);
            wr(PMC, 8'(m << 3));
        end
        for (int i = 0; i < 8; i++) begin
            @(posedge clk_i);
            bfuse <= i[2] ? 3'h0 : 3'h7;
            cmp <= i[1];
            conv <= i[0];
            repeat (3) @(posedge clk_i);
            @(negedge clk_i);
            chk(bg, i != 0);
        end
        @(posedge clk_i);
        bfuse <= 3'h7;
        wr(WDC, 8'h40);
        wait_for(1'b1, 1'b1, WDP + 300);
        rdm(WDC, 8'hFF, 8'hC0);
        wr(WDC, 8'hC0);
        rdm(WDC, 8'hFF, 8'h40);
        wait_for(1'b1, 1'b1, WDP + 300);
        pulse(3);
        rdm(WDC, 8'hFF, 8'h40);
        repeat (6) begin
            repeat (3000) @(posedge clk_i);
            pulse(2);
        end
        chk(irq, 1'b0);
        wr(WDC, 8'h48);
        wait_for(1'b1, 1'b1, WDP + 300);
        rdm(WDC, 8'hFF, 8'h88);
        wr(WDC, 8'h18);
        wr(WDC, 8'h80);
        rdm(WDC, 8'hFF, 8'h00);
        wr(WDC, 8'h08);
        wr(WDC, 8'h00);
        rdm(WDC, 8'h08, 8'h08);
        wait_for(1'b0, 1'b1, WDP + 300);
        wait_for(1'b0, 1'b0, 400);
        rdm(CAU, 8'h08, 8'h08);
        rdm(PMC, 8'hFF, 8'h00);
        rdm(WDC, 8'h08, 8'h08);
        wr(CAU, 8'h00);
        wr(WDC, 8'h18);
        wr(WDC, 8'h00);
        rdm(WDC, 8'h08, 8'h00);
        bfuse <= 3'h0;
        for (int s = 0; s < 3; s++) begin
            startup_time_fuse <= 2'(s / 2);
            cks <= 4'(s != 0);
            src[s] <= 1'b1;
            repeat (200) @(posedge clk_i);
            chk({port_rst, sys_rst}, 2'b11);
            src <= 3'h0;
            @(posedge clk_i);
            wait_for(1'b0, 1'b0, 400);
            chk(n >= (DLY << s) && n <= (DLY << s) + 10, 1'b1);
            rdm(CAU, 8'h07, 8'(1 << ((s + 1) % 3)));
            wr(CAU, 8'h00);
        end
        lock <= 1'b1;
        startup_time_fuse <= 2'd0;
        cks <= 4'h0;
        do_reset();
        rdm(WDC, 8'h08, 8'h08);
        wr(WDC, 8'h00);
        rdm(WDC, 8'h08, 8'h08);
        finish_test();
    end
endmodule : srw_top_tb
`default_nettype wire
